//--- rtl/psr_params.svh
// timing constants and reset values of the processor supervisor reset block
`ifndef PSR_PARAMS_SVH
`define PSR_PARAMS_SVH

// clock rate of clk_i in hertz
`define PSR_CLK_HZ 125000000
// cycles in one millisecond
`define PSR_CYC_PER_MS (`PSR_CLK_HZ / 1000)

// reset stretch after recovery, pushbutton or watchdog, in ms
`define PSR_HOLD_MS 250
`define PSR_HOLD_CYC (`PSR_CYC_PER_MS * `PSR_HOLD_MS)

// pushbutton must stay low this long to be accepted, in ms
`define PSR_DEBOUNCE_MS 10
`define PSR_DEBOUNCE_CYC (`PSR_CYC_PER_MS * `PSR_DEBOUNCE_MS)

// watchdog period, in ms
`define PSR_WDOG_MS 1000
`define PSR_WDOG_CYC (`PSR_CYC_PER_MS * `PSR_WDOG_MS)

// width of the down counters
`define PSR_TIMER_W 32

// reset values of the filtered pin levels: fail asserted, all selects idle
`define PSR_PINS_RST 6'h3F

// reset values of the sram enables (both blocked) and of the cause (power-up)
`define PSR_RAM_RST 2'h3
`define PSR_CAUSE_RST 3'h4

`endif

//--- rtl/psr_pkg.sv
// types shared by the processor supervisor reset block
package psr_pkg;

  // supervisor states, gray coded along fail -> hold -> run
  typedef enum logic [1:0] {
    PSR_PFAIL = 2'b01,
    PSR_HOLD = 2'b11,
    PSR_RUN = 2'b10
  } psr_state_type;

  // external inputs, all asynchronous to clk_i
  typedef struct packed {
    logic vcc_fail;
    logic rst_pin_n;
    logic wdog_strobe_n;
    logic ram_enable_in_n;
    logic upper_byte_select_n;
    logic lower_byte_select_n;
  } psr_pins_type;

  // enables driven to the sram, active low
  typedef struct packed {
    logic ram_enable_high_byte_n;
    logic ram_enable_low_byte_n;
  } psr_ram_type;

  // what started the reset in progress; button and wdog clear once back in run
  typedef struct packed {
    logic pfail;
    logic button;
    logic wdog;
  } psr_cause_type;

endpackage

//--- rtl/psr_timer.sv
// reloadable down counter used for hold, debounce and watchdog timing
`timescale 1ns/1ps
`include "psr_params.svh"

module psr_timer #(
  parameter int W = `PSR_TIMER_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  // control
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  // status
  output logic zero_o
);
  import psr_pkg::*;

  // remaining cycles
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  // load wins over counting so a restart is never missed
  assign nxt_cnt = load_i ? value_i : ((cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff);
  assign zero_o = (cnt_ff == '0);

  // counter register, frozen while en_i is low
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_ff <= '0;
    end else if (en_i) begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule

//--- rtl/psr_top.sv
// processor supervisor: power-fail, pushbutton and watchdog reset with sram guard
`timescale 1ns/1ps
`include "psr_params.svh"

module psr_top #(
  parameter int unsigned HOLD_CYC = `PSR_HOLD_CYC,
  parameter int unsigned DEBOUNCE_CYC = `PSR_DEBOUNCE_CYC,
  parameter int unsigned WDOG_CYC = `PSR_WDOG_CYC
) (
  // clock, reset, clock enable
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  // raw pin levels: comparator, reset pin readback, strobe, ram selects
  input psr_pkg::psr_pins_type pins_i,
  // open-drain processor reset pin
  output logic cpu_rst_n_o,
  output logic cpu_rst_oe_o,
  // sram chip enables
  output psr_pkg::psr_ram_type ram_o,
  // cause of the reset in progress; only pfail stays set once run resumes
  output psr_pkg::psr_cause_type cause_o
);
  import psr_pkg::*;

  localparam int W = `PSR_TIMER_W;
  localparam int NPIN = $bits(psr_pins_type);
  localparam logic [NPIN-1:0] PINS_RST = `PSR_PINS_RST;

  // ---- input synchronisers ----
  // raw pins as a plain vector for the per-bit loop
  logic [NPIN-1:0] raw_pins;
  // filtered levels, one per pin
  logic [NPIN-1:0] filt_ff;
  // filtered levels seen as named fields
  psr_pins_type pins_f;

  assign raw_pins = pins_i;

  // three flops per pin; a new level counts once stages two and three agree
  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic agree;

    // only the later stages are compared, the first one is never looked at
    assign agree = (s2_ff == s3_ff);

    // synchroniser chain and filtered level
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        s1_ff <= PINS_RST[i];
        s2_ff <= PINS_RST[i];
        s3_ff <= PINS_RST[i];
        filt_ff[i] <= PINS_RST[i];
      end else if (en_i) begin
        s1_ff <= raw_pins[i];
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
        if (agree) begin
          filt_ff[i] <= s3_ff;
        end
      end
    end
  end

  assign pins_f = psr_pins_type'(filt_ff);

  // ---- supervisor state ----
  psr_state_type state_ff;
  psr_state_type nxt_state;
  // pin drive register; the pin level written is always low
  logic rst_oe_ff;
  logic nxt_rst_oe;
  logic rst_n_ff;
  // sram enables and reset cause registers
  psr_ram_type ram_ff;
  psr_ram_type nxt_ram;
  psr_cause_type cause_ff;
  psr_cause_type nxt_cause;

  // timer handshakes
  logic hold_load;
  logic hold_zero;
  logic deb_load;
  logic deb_zero;
  logic wdog_load;
  logic wdog_zero;

  // decoded events
  logic in_run;
  logic pf_now;
  logic button_low;
  logic button_hit;
  logic strobe_hit;
  logic wdog_hit;
  logic guard;

  assign in_run = (state_ff == PSR_RUN);
  assign pf_now = pins_f.vcc_fail;

  // pin low while we do not drive it
  // the readback of our own drive is masked, else the pin would retrigger itself;
  // the debounce time also covers the sync delay after we let go
  assign button_low = !pins_f.rst_pin_n && !rst_oe_ff;

  // debounce by stable low level
  // any high level or any reset activity restarts the debounce window
  assign deb_load = !button_low || !in_run;
  assign button_hit = in_run && button_low && deb_zero;

  // strobe restarts watchdog
  // a strobe held low keeps restarting, so only a missing strobe can expire
  assign strobe_hit = !pins_f.wdog_strobe_n;
  assign wdog_load = strobe_hit || !in_run;

  assign wdog_hit = in_run && wdog_zero && !strobe_hit;

  // hold timer reloads while the supply is bad
  // the hold window is counted from the recovery edge, not from the fall
  assign hold_load = (state_ff == PSR_PFAIL) || (in_run && (button_hit || wdog_hit));

  // state transitions
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      // supply bad: stay until the comparator reports recovery
      PSR_PFAIL: begin
        if (!pf_now) begin
          nxt_state = PSR_HOLD;
        end
      end
      // stretching the reset pulse
      PSR_HOLD: begin
        if (pf_now) begin
          nxt_state = PSR_PFAIL;
        end else if (hold_zero) begin
          nxt_state = PSR_RUN;
        end
      end
      // processor running
      PSR_RUN: begin
        if (pf_now) begin
          nxt_state = PSR_PFAIL;
        end else if (button_hit || wdog_hit) begin
          nxt_state = PSR_HOLD;
        end
      end
    endcase
  end

  // supply fail drives reset
  // the pin is driven in every state but run, and at once from a fail in run
  assign nxt_rst_oe = (nxt_state != PSR_RUN);

  // cause bookkeeping: latched on the entry into a reset; pfail kept until the next, button and wdog cleared once back in run
  assign nxt_cause.pfail = (in_run && pf_now) ? 1'b1 :
                           ((in_run && (button_hit || wdog_hit)) ? 1'b0 :
                           (cause_ff.pfail || (state_ff == PSR_PFAIL)));
  assign nxt_cause.button = (in_run && !pf_now) ? button_hit : cause_ff.button && !pf_now;
  assign nxt_cause.wdog = (in_run && !pf_now) ? (wdog_hit && !button_hit) :
                          cause_ff.wdog && !pf_now;

  // block sram during transients
  // blocked while the supply reads bad and through the fail state; the
  // recovery hold lets access through, since the supply is back by then
  assign guard = pf_now || (state_ff == PSR_PFAIL) || (nxt_state == PSR_PFAIL);

  // byte enables from select and enable
  assign nxt_ram.ram_enable_high_byte_n =
    guard || pins_f.ram_enable_in_n || pins_f.upper_byte_select_n;
  assign nxt_ram.ram_enable_low_byte_n =
    guard || pins_f.ram_enable_in_n || pins_f.lower_byte_select_n;

  // state and output registers; power-up starts in the hold period
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= PSR_HOLD;
      rst_oe_ff <= 1'b1;
      rst_n_ff <= 1'b0;
      ram_ff <= `PSR_RAM_RST;
      cause_ff <= `PSR_CAUSE_RST;
    end else if (en_i) begin
      state_ff <= nxt_state;
      rst_oe_ff <= nxt_rst_oe;
      rst_n_ff <= 1'b0;
      ram_ff <= nxt_ram;
      cause_ff <= nxt_cause;
    end
  end

  // ---- timers ----
  // reset stretch after recovery, pushbutton or watchdog
  psr_timer #(
    .W(W)
  ) u_hold (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .en_i(en_i),
    .load_i(hold_load),
    .value_i(W'(HOLD_CYC)),
    .zero_o(hold_zero)
  );

  // pushbutton debounce window
  psr_timer #(
    .W(W)
  ) u_deb (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .en_i(en_i),
    .load_i(deb_load),
    .value_i(W'(DEBOUNCE_CYC)),
    .zero_o(deb_zero)
  );

  // watchdog period
  psr_timer #(
    .W(W)
  ) u_wdog (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .en_i(en_i),
    .load_i(wdog_load),
    .value_i(W'(WDOG_CYC)),
    .zero_o(wdog_zero)
  );

  // outputs straight from registers
  assign cpu_rst_n_o = rst_n_ff;
  assign cpu_rst_oe_o = rst_oe_ff;
  assign ram_o = ram_ff;
  assign cause_o = cause_ff;

endmodule

//--- dv/psr_host_model.sv
// host and pushbutton model: reset pin wire and watchdog strobe
`timescale 1ns/1ps
module psr_host_model (
  // clock and supervisor drive
  input wire logic clk_i,
  input wire logic oe_i,
  // bench controls
  input wire logic press_i,
  input wire logic strobe_on_i,
  // levels seen by the supervisor
  output logic pin_n_o,
  output logic strobe_n_o
);
  logic [3:0] cnt_ff = 4'h0; // strobe pacing
  initial strobe_n_o = 1'b1;
  assign pin_n_o = !(oe_i || press_i);
  // strobe every 16 cycles; 3 cycles low so the glitch filter keeps it
  always @(posedge clk_i) begin
    cnt_ff <= #1 cnt_ff + 4'h1;
    strobe_n_o <= #1 !(strobe_on_i && cnt_ff < 4'h3);
  end
endmodule

//--- dv/psr_top_assertions.sv
// port checks of the supervisor
`timescale 1ns/1ps
module psr_top_checker #(
  parameter int unsigned HOLD_CYC = 20,
  parameter int unsigned DEBOUNCE_CYC = 8,
  parameter int unsigned WDOG_CYC = 40
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  // ports
  input psr_pkg::psr_pins_type pins_i,
  input logic cpu_rst_n_o,
  input logic cpu_rst_oe_o,
  input psr_pkg::psr_ram_type ram_o,
  input psr_pkg::psr_cause_type cause_o
);
  import psr_pkg::*;
  int unsigned hi_ff, wd_ff, bt_ff; // runs: reset on, no strobe, pin low
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // run counters; the two watch runs only grow while the pin is released
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hi_ff <= 0;
      wd_ff <= 0;
      bt_ff <= 0;
    end else begin
      hi_ff <= cpu_rst_oe_o ? hi_ff + 1 : 0;
      wd_ff <= (!cpu_rst_oe_o && pins_i.wdog_strobe_n) ? wd_ff + 1 : 0;
      bt_ff <= (!cpu_rst_oe_o && !pins_i.rst_pin_n) ? bt_ff + 1 : 0;
    end
  end
  fail_reset_a: assert property (pins_i.vcc_fail [*6] |-> cpu_rst_oe_o)
    else $error("reset not driven in supply fail");
  ram_guard_a: assert property (pins_i.vcc_fail [*6] |-> ram_o == 2'h3)
    else $error("sram enabled in supply fail");
  ram_follow_a: assert property ((!cpu_rst_oe_o && $stable(pins_i)) [*6] |->
    ram_o == {pins_i.ram_enable_in_n | pins_i.upper_byte_select_n | pins_i.vcc_fail,
      pins_i.ram_enable_in_n | pins_i.lower_byte_select_n | pins_i.vcc_fail})
    else $error("sram enables wrong");
  hold_time_a: assert property ($fell(cpu_rst_oe_o) |-> hi_ff > HOLD_CYC)
    else $error("reset released early");
  wdog_fire_a: assert property (wd_ff <= WDOG_CYC + 10)
    else $error("watchdog did not fire");
  wdog_late_a: assert property ($rose(cpu_rst_oe_o) && cause_o == 3'h1 |-> wd_ff >= WDOG_CYC)
    else $error("watchdog fired early");
  button_min_a: assert property ($rose(cpu_rst_oe_o) && cause_o == 3'h2 |-> bt_ff >= DEBOUNCE_CYC)
    else $error("button not debounced");
  drive_low_a: assert property (cpu_rst_oe_o |-> !cpu_rst_n_o)
    else $error("reset pin driven high");
  cover property ($rose(cpu_rst_oe_o) && cause_o == 3'h4);
  cover property ($rose(cpu_rst_oe_o) && cause_o == 3'h2);
  cover property ($rose(cpu_rst_oe_o) && cause_o == 3'h1);
endmodule
bind psr_top psr_top_checker #(.HOLD_CYC(HOLD_CYC), .DEBOUNCE_CYC(DEBOUNCE_CYC),
  .WDOG_CYC(WDOG_CYC)) chk_u (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(en_i),
  .pins_i(pins_i), .cpu_rst_n_o(cpu_rst_n_o), .cpu_rst_oe_o(cpu_rst_oe_o),
  .ram_o(ram_o), .cause_o(cause_o));

//--- dv/tb_psr_top.sv
// self-checking bench of the supervisor
`timescale 1ns/1ps
module tb_psr_top;
  import psr_pkg::*;
  localparam int HOLD = 20; // short counts keep the run brief
  localparam int DEB = 8;
  localparam int WDOG = 40;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic vcc = 1'b0, ce = 1'b1, up = 1'b1, lo = 1'b1; // pin levels
  logic press = 1'b0, strobe_on = 1'b1, en = 1'b1; // model controls, clock enable
  logic pin_n, strobe_n, oe, drv_n;
  psr_ram_type ram;
  psr_cause_type cause;
  int failures = 0;
  int n_checks = 0;
  int n;
  psr_top #(.HOLD_CYC(HOLD), .DEBOUNCE_CYC(DEB), .WDOG_CYC(WDOG)) dut_u (.clk_i(clk_i),
    .nrst_i(nrst_i), .en_i(en), .pins_i({vcc, pin_n, strobe_n, ce, up, lo}),
    .cpu_rst_n_o(drv_n), .cpu_rst_oe_o(oe), .ram_o(ram), .cause_o(cause));
  psr_host_model host_u (.clk_i(clk_i), .oe_i(oe), .press_i(press),
    .strobe_on_i(strobe_on), .pin_n_o(pin_n), .strobe_n_o(strobe_n));
  initial forever #4 clk_i = ~clk_i;
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // inputs move 1 ns after the edge
  task automatic step(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask
  // bounded wait for the reset drive level
  task automatic wait_oe(input logic v, output int c);
    c = 0;
    while (oe !== v && c < 500) begin
      step(1);
      c++;
    end
    if (c >= 500) chk("wait limit", 8'(oe), 8'(v));
  endtask
  task automatic t_sram();
    for (int i = 0; i < 8; i++) begin
      {ce, up, lo} = 3'(i);
      step(6);
      chk("ram", 8'(ram), 8'({ce | up, ce | lo}));
    end
    $display("done sram");
  endtask
  task automatic t_fail();
    vcc = 1'b1;
    {ce, up, lo} = 3'h0;
    step(6);
    chk("fail oe", 8'(oe), 8'h01);
    chk("fail ram", 8'(ram), 8'h03);
    chk("fail cause", 8'(cause), 8'h04);
    vcc = 1'b0;
    wait_oe(1'b0, n);
    chk("recovery", 8'(n > HOLD && n < HOLD + 9), 8'h01);
    chk("ram after", 8'(ram), 8'h00);
    {ce, up, lo} = 3'h7;
    $display("done fail");
  endtask
  // clock enable low freezes a pending recovery and the sram enables
  task automatic t_freeze();
    vcc = 1'b1;
    step(6);
    en = 1'b0;
    vcc = 1'b0;
    {ce, up, lo} = 3'h0;
    step(HOLD + 10);
    chk("frozen oe", 8'(oe), 8'h01);
    chk("frozen ram", 8'(ram), 8'h03);
    en = 1'b1;
    wait_oe(1'b0, n);
    chk("thawed", 8'(n > HOLD && n < HOLD + 9), 8'h01);
    chk("thawed ram", 8'(ram), 8'h00);
    {ce, up, lo} = 3'h7;
    $display("done freeze");
  endtask
  task automatic t_button(input int len, input logic exp);
    press = 1'b1;
    step(len);
    press = 1'b0;
    step(3);
    chk("button oe", 8'(oe), 8'(exp));
    if (exp) begin
      chk("button cause", 8'(cause), 8'h02);
      chk("pin level", 8'(drv_n), 8'h00);
      wait_oe(1'b0, n);
      chk("button hold", 8'(n > 8 && n < HOLD + 3), 8'h01);
    end
    $display("done button");
  endtask
  task automatic t_wdog();
    step(3 * WDOG);
    chk("strobed", 8'(oe), 8'h00);
    strobe_on = 1'b0;
    wait_oe(1'b1, n);
    chk("timeout", 8'(n > WDOG - 12 && n < WDOG + 10), 8'h01);
    chk("wdog cause", 8'(cause), 8'h01);
    strobe_on = 1'b1;
    wait_oe(1'b0, n);
    $display("done wdog");
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    step(4);
    nrst_i = 1'b1;
    wait_oe(1'b0, n);
    chk("power-up", 8'(n > HOLD && n < HOLD + 9), 8'h01);
    chk("power-up cause", 8'(cause), 8'h04);
    t_sram();
    t_fail();
    t_freeze();
    t_button(3, 1'b0);
    t_button(DEB + 10, 1'b1);
    t_wdog();
    conclude();
  end
  // hang guard, several times the expected run
  initial begin
    step(3000);
    failures++;
    conclude();
  end
endmodule
